// ### ssr_consts.vh
/*
 * Constants for the simultaneous-sample parallel readout block:
 * interface mode codes, channel count, result width and conversion timing.
 * Assumes a 100 MHz system clock; included by its bare name.
 */
`ifndef SSR_CONSTS_VH
`define SSR_CONSTS_VH

`define SSR_CLK_PERIOD_NS 10
`define SSR_CONV_TIME_NS 2000
`define SSR_CONV_CYCLES (`SSR_CONV_TIME_NS / `SSR_CLK_PERIOD_NS)
`define SSR_NUM_CHANNELS 8
`define SSR_RESULT_WIDTH 18
`define SSR_BUS_WIDTH 16
`define SSR_MODE_PARALLEL 2'h0
`define SSR_MODE_BYTE 2'h1
`define SSR_MODE_SERIAL 2'h2

`endif

// ### ssr_edge_sync.v
/*
 * Two-flop synchroniser with rising and falling edge pulses.
 * Assumes the input is asynchronous to clk; rise and fall are one-cycle pulses, level is the synchronised input.
 */
`timescale 1ns/1ps
module ssr_edge_sync
(
	input wire clk,
	input wire rst,
	input wire pinIn,
	output wire level,
	output wire rise,
	output wire fall
);

reg meta_reg;
reg sync_reg;
reg last_reg;

// first flop feeds only the second; edges come from the later pair
always @(posedge clk)
begin
	if (rst)
	begin
		meta_reg <= 1'b0;
		sync_reg <= 1'b0;
		last_reg <= 1'b0;
	end
	else
	begin
		meta_reg <= pinIn;
		sync_reg <= meta_reg;
		last_reg <= sync_reg;
	end
end

assign level = sync_reg;
assign rise = sync_reg & ~last_reg;
assign fall = ~sync_reg & last_reg;

endmodule

// ### ssr_readout.v
/*
 * Conversion control and parallel readout for an 8-channel simultaneous
 * sampling 18-bit converter. Holds sampled codes, converts them over a
 * fixed busy period, and steps results out on the 16-bit bus.
 * Assumes the analog path delivers sampled codes on sampleCodes; host pins
 * are asynchronous and are synchronised here before use.
 */
`timescale 1ns/1ps
`include "ssr_consts.vh"
module ssr_readout
#(
	parameter NUM_CH = `SSR_NUM_CHANNELS,
	parameter RES_W = `SSR_RESULT_WIDTH,
	parameter CONV_CYCLES = `SSR_CONV_CYCLES
)
(
	input wire clk,
	input wire rst,
	input wire sampleStartGroupA,
	input wire sampleStartGroupB,
	input wire chipSelect_n,
	input wire readStrobe_n,
	input wire interfaceSelect,
	input wire byteSerialSelect,
	input wire [NUM_CH*RES_W-1:0] sampleCodes,
	output reg busy,
	output reg [`SSR_BUS_WIDTH-1:0] parallelDataBusOut,
	output reg parallelDataBusOe,
	output reg firstChannelFlagOut,
	output reg firstChannelFlagOe,
	output reg [1:0] interfaceMode
);

localparam HALF = NUM_CH / 2;
localparam ST_IDLE = 2'h0;
localparam ST_WAIT_B = 2'h1;
localparam ST_WAIT_A = 2'h2;
localparam ST_CONV = 2'h3;

////////////////////////////////////////////////////////////////////////////
// pin synchronisers

wire startALvl;
wire startARise;
wire startBLvl;
wire startBRise;
wire csLvl;
wire csRise;
wire csFall;
wire rdLvl;
wire rdFall;
wire ifSelLvl;
wire byteSelLvl;

ssr_edge_sync syncStartA (.clk(clk), .rst(rst), .pinIn(sampleStartGroupA),
	.level(startALvl), .rise(startARise), .fall());
ssr_edge_sync syncStartB (.clk(clk), .rst(rst), .pinIn(sampleStartGroupB),
	.level(startBLvl), .rise(startBRise), .fall());
ssr_edge_sync syncCs (.clk(clk), .rst(rst), .pinIn(chipSelect_n),
	.level(csLvl), .rise(csRise), .fall(csFall));
ssr_edge_sync syncRd (.clk(clk), .rst(rst), .pinIn(readStrobe_n),
	.level(rdLvl), .rise(), .fall(rdFall));
ssr_edge_sync syncIf (.clk(clk), .rst(rst), .pinIn(interfaceSelect),
	.level(ifSelLvl), .rise(), .fall());
ssr_edge_sync syncBs (.clk(clk), .rst(rst), .pinIn(byteSerialSelect),
	.level(byteSelLvl), .rise(), .fall());

////////////////////////////////////////////////////////////////////////////
// mode decode from strapped pins

reg [1:0] modeNext;

always @*
begin
	if (!ifSelLvl)
		modeNext = `SSR_MODE_PARALLEL;
	else if (byteSelLvl)
		modeNext = `SSR_MODE_BYTE;
	else
		modeNext = `SSR_MODE_SERIAL;
end

always @(posedge clk)
begin
	if (rst)
		interfaceMode <= `SSR_MODE_PARALLEL;
	else
		interfaceMode <= modeNext;
end

////////////////////////////////////////////////////////////////////////////
// sample hold and conversion sequencing

reg [1:0] state_reg;
reg [NUM_CH*RES_W-1:0] held_reg;
reg [NUM_CH*RES_W-1:0] result_reg;
reg [31:0] convCnt_reg;
reg busyFall_reg;

// both edges in one cycle is the common-start case: all eight held at once
always @(posedge clk)
begin
	if (rst)
	begin
		state_reg <= ST_IDLE;
		held_reg <= {NUM_CH*RES_W{1'b0}};
		result_reg <= {NUM_CH*RES_W{1'b0}};
		convCnt_reg <= 32'h0;
		busy <= 1'b0;
		busyFall_reg <= 1'b0;
	end
	else
	begin
		busyFall_reg <= 1'b0;
		case (state_reg)
			ST_IDLE:
			begin
				if (startARise)
					held_reg[HALF*RES_W-1:0] <= sampleCodes[HALF*RES_W-1:0];
				if (startBRise)
					held_reg[NUM_CH*RES_W-1:HALF*RES_W] <=
						sampleCodes[NUM_CH*RES_W-1:HALF*RES_W];
				if (startARise && startBRise)
				begin
					state_reg <= ST_CONV;
					busy <= 1'b1;
					convCnt_reg <= 32'h0;
				end
				else if (startARise)
					state_reg <= ST_WAIT_B;
				else if (startBRise)
					state_reg <= ST_WAIT_A;
			end
			ST_WAIT_B:
			begin
				if (startBRise)
				begin
					held_reg[NUM_CH*RES_W-1:HALF*RES_W] <=
						sampleCodes[NUM_CH*RES_W-1:HALF*RES_W];
					state_reg <= ST_CONV;
					busy <= 1'b1;
					convCnt_reg <= 32'h0;
				end
			end
			ST_WAIT_A:
			begin
				if (startARise)
				begin
					held_reg[HALF*RES_W-1:0] <= sampleCodes[HALF*RES_W-1:0];
					state_reg <= ST_CONV;
					busy <= 1'b1;
					convCnt_reg <= 32'h0;
				end
			end
			ST_CONV:
			begin
				// start edges here are ignored; host keeps them off while busy
				if (convCnt_reg >= CONV_CYCLES - 1)
				begin
					result_reg <= held_reg;
					busy <= 1'b0;
					busyFall_reg <= 1'b1;
					state_reg <= ST_IDLE;
				end
				else
					convCnt_reg <= convCnt_reg + 32'h1;
			end
			default:
				state_reg <= ST_IDLE;
		endcase
	end
end

////////////////////////////////////////////////////////////////////////////
// parallel readout stepping

reg [2:0] chPtr_reg;
reg halfSel_reg;
reg [4:0] strobeCnt_reg;
reg frameDone_reg;
wire parMode = (modeNext == `SSR_MODE_PARALLEL);
wire [RES_W-1:0] chCode = result_reg[chPtr_reg*RES_W +: RES_W];
wire stepNow = parMode && rdFall && !csLvl && !frameDone_reg;

// result_reg only changes at busy fall, so reads during busy see old data
always @(posedge clk)
begin
	if (rst)
	begin
		chPtr_reg <= 3'h0;
		halfSel_reg <= 1'b0;
		strobeCnt_reg <= 5'h0;
		frameDone_reg <= 1'b0;
		parallelDataBusOut <= 16'h0000;
		parallelDataBusOe <= 1'b0;
		firstChannelFlagOut <= 1'b0;
		firstChannelFlagOe <= 1'b0;
	end
	else if (busyFall_reg || csRise || !parMode)
	begin
		chPtr_reg <= 3'h0;
		halfSel_reg <= 1'b0;
		strobeCnt_reg <= 5'h0;
		frameDone_reg <= 1'b0;
		if (csRise || !parMode)
		begin
			parallelDataBusOe <= 1'b0;
			firstChannelFlagOe <= 1'b0;
		end
	end
	else
	begin
		if (csFall)
			parallelDataBusOe <= 1'b1;
		if (stepNow)
		begin
			parallelDataBusOe <= 1'b1;
			firstChannelFlagOe <= 1'b1;
			strobeCnt_reg <= strobeCnt_reg + 5'h1;
			if (!halfSel_reg)
				parallelDataBusOut <= chCode[RES_W-1:RES_W-16];
			else
				parallelDataBusOut <= {chCode[1:0], 14'h0000};
			// flag high for the two strobes of channel 1, low from the third
			firstChannelFlagOut <= (strobeCnt_reg < 5'h2);
			halfSel_reg <= ~halfSel_reg;
			if (halfSel_reg)
			begin
				if (chPtr_reg == NUM_CH - 1)
				begin
					chPtr_reg <= 3'h0;
					frameDone_reg <= 1'b1;
				end
				else
					chPtr_reg <= chPtr_reg + 3'h1;
			end
		end
	end
end

endmodule

// ### ssr_readout_sva.sv
/* assertions on the ssr_readout ports.
   assumes straps stay put for several cycles and start pins are held high. */
`timescale 1ns/1ps
module ssr_readout_sva
#(
	parameter CONV_CYCLES = 200
)
(
	input wire clk,
	input wire rst,
	input wire sampleStartGroupA,
	input wire sampleStartGroupB,
	input wire chipSelect_n,
	input wire interfaceSelect,
	input wire byteSerialSelect,
	input wire busy,
	input wire parallelDataBusOe,
	input wire firstChannelFlagOe,
	input wire [1:0] interfaceMode
);
	reg [15:0] busyCnt_reg;
	// length of the busy pulse; cleared when busy drops
	always @(posedge clk)
		busyCnt_reg <= (rst || !busy) ? 16'h0 : busyCnt_reg + 16'h1;
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	a_busy_len: assert property ($fell(busy) |-> busyCnt_reg == CONV_CYCLES)
		else $error("busy length wrong");
	a_busy_max: assert property (busy |-> busyCnt_reg < CONV_CYCLES)
		else $error("busy too long");
	a_busy_start: assert property ($rose(sampleStartGroupA) && $rose(sampleStartGroupB) && !busy
		|-> ##[2:6] busy)
		else $error("busy missing after start");
	a_both_groups: assert property ($rose(busy)
		|-> $past(sampleStartGroupA, 3) && $past(sampleStartGroupB, 3))
		else $error("conversion before both groups");
	a_par_mode: assert property ((!interfaceSelect)[*5] |-> interfaceMode == 2'h0)
		else $error("parallel mode not decoded");
	a_mode_sel: assert property ((interfaceSelect && $stable(byteSerialSelect))[*5]
		|-> interfaceMode == (byteSerialSelect ? 2'h1 : 2'h2))
		else $error("byte or serial mode wrong");
	a_no_par_other: assert property (interfaceMode != 2'h0 |-> !parallelDataBusOe)
		else $error("bus driven outside parallel mode");
	a_bus_float: assert property (chipSelect_n[*5]
		|-> !parallelDataBusOe && !firstChannelFlagOe)
		else $error("bus not released");
endmodule
bind ssr_readout ssr_readout_sva #(.CONV_CYCLES(CONV_CYCLES)) chk (.*);

// ### ssr_host_model.sv
/* host reader: one frame of sixteen read strobes per go pulse.
   assumes a single device; phases of five cycles keep the 3 cycle minimum. */
`timescale 1ns/1ps
module ssr_host_model
(
	input wire clk,
	input wire go,
	output reg chipSelect_n,
	output reg readStrobe_n,
	output reg done
);
	integer k;
	initial
	begin
		chipSelect_n = 1'b1;
		readStrobe_n = 1'b1;
		done = 1'b0;
	end
	// select, step all slots in order, then release to end the frame
	always @(posedge go)
	begin
		done = 1'b0;
		@(posedge clk);
		#1 chipSelect_n = 1'b0;
		for (k = 0; k < 16; k = k + 1)
		begin
			repeat (5) @(posedge clk);
			#1 readStrobe_n = 1'b0;
			repeat (5) @(posedge clk);
			#1 readStrobe_n = 1'b1;
		end
		repeat (5) @(posedge clk);
		#1 chipSelect_n = 1'b1;
		done = 1'b1;
	end
endmodule

// ### test_ssr_readout.sv
/* self-checking bench for ssr_readout with the host model.
   assumes CONV_CYCLES 300 so a frame fits inside one busy period. */
`timescale 1ns/1ps
module test_ssr_readout;
	reg clk = 1'b0;
	reg rst = 1'b1;
	reg grpA = 1'b0;
	reg grpB = 1'b0;
	reg ifSel = 1'b0;
	reg bsSel = 1'b0;
	reg go = 1'b0;
	reg [143:0] codes = 144'h0;
	reg [143:0] res = 144'h0;
	reg [143:0] old;
	reg [31:0] seed;
	wire csN, rdN, busy, dOe, fOut, fOe, done;
	wire [15:0] dOut;
	wire [1:0] mode;
	reg [18:0] q[$];
	integer num_errors = 0;
	integer tests_run = 0;
	integer i;
	always #5 clk = ~clk;
	ssr_readout #(.CONV_CYCLES(300)) uut (.clk(clk), .rst(rst), .sampleStartGroupA(grpA),
		.sampleStartGroupB(grpB), .chipSelect_n(csN), .readStrobe_n(rdN),
		.interfaceSelect(ifSel), .byteSerialSelect(bsSel), .sampleCodes(codes), .busy(busy),
		.parallelDataBusOut(dOut), .parallelDataBusOe(dOe), .firstChannelFlagOut(fOut),
		.firstChannelFlagOe(fOe), .interfaceMode(mode));
	ssr_host_model host (.clk(clk), .go(go), .chipSelect_n(csN), .readStrobe_n(rdN),
		.done(done));
	//////////////////////////////////////////////////////////////////
	task tick(input integer n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task tally_and_finish;
		$display("counts: %0d compared, %0d mismatched", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task chk(input [18:0] got, input [18:0] exp);
		tests_run = tests_run + 1;
		if (got !== exp)
		begin
			num_errors = num_errors + 1;
			$display("mismatch at %0t: bus %h want %h", $time, got, exp);
		end
	endtask
	task chkMode(input [1:0] got, input [1:0] exp);
		tests_run = tests_run + 1;
		if (got !== exp)
		begin
			num_errors = num_errors + 1;
			$display("mismatch at %0t: mode %h want %h", $time, got, exp);
		end
	endtask
	// bounded wait on busy (sel 0) or frame done (sel 1)
	task waitFor(input integer sel, input reg lvl);
		for (i = 0; i < 2000 && (sel ? done : busy) !== lvl; i = i + 1)
			tick(1);
		if ((sel ? done : busy) !== lvl)
		begin
			num_errors = num_errors + 1;
			$display("mismatch at %0t: wait ran out", $time);
			tally_and_finish;
		end
	endtask
	function [143:0] rnd(input integer d);
		reg [159:0] t;
		begin
			t = {$urandom, $urandom, $urandom, $urandom, $urandom};
			rnd = t[143:0];
		end
	endfunction
	// start pins: joined, or group B later with new upper codes
	task convert(input integer split);
		reg [143:0] t;
		grpA = 1'b0;
		grpB = 1'b0;
		tick(4);
		old = res;
		codes = rnd(0);
		grpA = 1'b1;
		grpB = (split == 0);
		if (split != 0)
		begin
			tick(10);
			t = rnd(0);
			codes[143:72] = t[71:0];
			grpB = 1'b1;
		end
		res = codes;
		tick(6);
		codes = rnd(0); // later changes must not reach the results
	endtask
	task frame(input [143:0] r);
		integer k;
		for (k = 0; k < 16; k = k + 1)
			q.push_back({2'b11, k < 2, k[0] ? {r[k/2*18+1 -: 2], 14'h0} : r[k/2*18+17 -: 16]});
		go = 1'b1;
		tick(1);
		go = 1'b0;
		waitFor(1, 1'b1);
	endtask
	// each strobe's result against the oldest note
	always @(posedge rdN)
		if (csN === 1'b0)
			chk({dOe, fOe, fOut, dOut}, q.size() ? q.pop_front() : 19'h0);
	//////////////////////////////////////////////////////////////////
	initial
	begin
		seed = $urandom(32'h75F2);
		tick(3);
		rst = 1'b0;
		tick(3);
		convert(0);
		waitFor(0, 1'b1);
		waitFor(0, 1'b0);
		frame(res);
		$display("test common start done");
		convert(1);
		waitFor(0, 1'b1);
		waitFor(0, 1'b0);
		frame(res);
		$display("test two groups done");
		convert(0);
		waitFor(0, 1'b1);
		frame(old);
		waitFor(0, 1'b0);
		frame(res);
		$display("test read during busy done");
		for (i = 0; i < 3; i = i + 1)
		begin
			ifSel = (i > 0);
			bsSel = (i == 1);
			tick(8);
			chkMode(mode, i[1:0]);
		end
		$display("test modes done");
		tally_and_finish;
	end
endmodule
